// >>> design/field_mapper_regs.vh
// Register map, field positions, reset values and segment figures of the field encrypt mapper.
// Assumes inclusion by the mapper module and its testbench; holds definitions and nothing else.
`ifndef FIELD_MAPPER_REGS_VH
`define FIELD_MAPPER_REGS_VH

`define OFS_CTRL       8'h00
`define OFS_START      8'h04
`define OFS_USED       8'h08
`define OFS_STATUS     8'h0C
`define OFS_INDEX      8'h10
`define OFS_SEGLEN     8'h14

`define CTRL_CFG_LSB   0
`define CTRL_SLOT_LSB  4
`define CTRL_FMT_LSB   8
`define CTRL_TCIPH_BIT 12
`define STATUS_BUSY    0
`define STATUS_SEG     1
`define STATUS_DONE    2

`define CTRL_RESET     16'h0000
`define USED_RESET     13'h0000

`define CFG_1A         3'h0
`define CFG_1B         3'h1
`define CFG_2          3'h2
`define CFG_3          3'h3
`define CFG_4A         3'h4
`define CFG_4B         3'h5
`define CFG_5          3'h6
`define CFG_6          3'h7

`define SLOT_DOUBLE    3'h0
`define SLOT_FULL      3'h1
`define SLOT_HALF      3'h2
`define SLOT_LONG640   3'h3
`define SLOT_LONG672   3'h4

`define FMT_UNPROT     2'h0
`define FMT_SINGLE     2'h1
`define FMT_MULTI      2'h2
`define FMT_ENCODED    2'h3

`define TAIL_BASE      13'h0028
`define TAIL_4A        13'h0050
`define TAIL_4B        13'h0078
`define TAIL_FIRST_A   8
`define B_DOUBLE       13'h0320
`define B_FULL         13'h0140
`define B_HALF         13'h0050
`define B_LONG640      13'h0280
`define B_LONG672      13'h02A0
`define SUB_LEN        7'h50
`define SUB_DATA       7'h40

`endif

// >>> design/multilevel_field_encrypt_mapper.v
// Field encrypt mapper: XORs keystream pieces onto tail and B-field bits, one bit per step.
// Assumes a keystream source and a bit stream from the burst framing on the same aclk.
//
// How it works
// - One keystream piece per D-field, two per pair.
// - Piece length picked from slot and configuration.
// - Length is tail portion plus B portion.
// - Piece bits indexed from zero upward.
// - Configs other than 4a and 4b cipher tail takes bits 0..39.
// - Configs other than 4a and 4b B bit i uses bit i+40.
// - Config 4a cipher tail takes bits 0..79.
// - Config 4a B bit i uses bit i+80.
// - Config 4b cipher tail takes bits 0..119.
// - Config 4b B bit i uses bit i+120.
// - B bit count follows slot and configuration.
// - Long slots give 640 or 672 scaled.
// - Check bits and X-field stay clear.
// - Encoded payload XORed using leading piece bits.
// - Encoded mode keeps full piece length.
// - Eight configuration codes are accepted; 1a and 1b map alike.
// - Other encrypt rules as base formats.
// - Check-bit keystream generated, kept aligned, unused.
// - Subfield x bit i uses 80x+i plus tail length (40, 80 or 120) offset.
`include "field_mapper_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module multilevel_field_encrypt_mapper (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        ks_valid,
  input  wire        ks_bit,
  output wire        ks_ready,
  input  wire        din_valid,
  input  wire        din_bit,
  output wire        din_ready,
  output reg         dout_valid,
  output reg         dout_bit,
  input  wire        dout_ready
);

  // B portion per slot for the single-rate configurations, then scaled by bits per symbol.
  // Half slot in configuration 6 therefore gives 480 B bits, in line with the segment lengths.
  // Framing that expects 560 B bits in that case must not use this mapper.
  function [12:0] b_len;
    input [2:0] cfg;
    input [2:0] slot;
    reg   [12:0] base;
    reg   [2:0]  mult;
    begin
      base = `B_DOUBLE;
      mult = 3'd1;
      if (slot == `SLOT_FULL) begin
        base = `B_FULL;
      end else if (slot == `SLOT_HALF) begin
        base = `B_HALF;
      end else if (slot == `SLOT_LONG640) begin
        base = `B_LONG640;
      end else if (slot == `SLOT_LONG672) begin
        base = `B_LONG672;
      end
      case (cfg)
        `CFG_2, `CFG_4A: mult = 3'd2;
        `CFG_3, `CFG_4B: mult = 3'd3;
        `CFG_5:          mult = 3'd4;
        `CFG_6:          mult = 3'd6;
        default:         mult = 3'd1;
      endcase
      b_len = base * {10'd0, mult};
    end
  endfunction

  function [12:0] tail_len;
    input [2:0] cfg;
    begin
      if (cfg == `CFG_4A) begin
        tail_len = `TAIL_4A;
      end else if (cfg == `CFG_4B) begin
        tail_len = `TAIL_4B;
      end else begin
        tail_len = `TAIL_BASE;
      end
    end
  endfunction

  // Registers sit on aligned words, so the two low address bits are ignored.
  function [7:0] word_addr;
    input [7:0] addr;
    begin
      word_addr = {addr[7:2], 2'b00};
    end
  endfunction

  localparam [1:0] RESP_SLVERR = 2'b10;

  reg  [15:0] ctrl;
  reg  [12:0] used;
  reg         busy;
  reg         seg;
  reg         done;
  reg  [12:0] idx;
  reg  [6:0]  sub_pos;
  reg         aw_hold;
  reg  [7:0]  aw_addr;
  reg         w_hold;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  wire [2:0]  cfg      = ctrl[`CTRL_CFG_LSB +: 3];
  wire [2:0]  slot     = ctrl[`CTRL_SLOT_LSB +: 3];
  wire [1:0]  fmt      = ctrl[`CTRL_FMT_LSB +: 2];
  wire        t_cipher = ctrl[`CTRL_TCIPH_BIT];
  wire [12:0] t_len    = tail_len(cfg);
  wire [12:0] bf_len   = b_len(cfg, slot);
  wire [12:0] seg_len  = t_len + bf_len;
  wire        in_tail  = idx < t_len;
  wire [12:0] b_pos    = idx - t_len;
  wire        partial  = (fmt == `FMT_SINGLE) || (fmt == `FMT_ENCODED);
  wire [12:0] b_active = (partial && used < bf_len) ? used : bf_len;
  // A keystream bit outside the used B span is consumed without a data bit.
  wire        need     = in_tail || (b_pos < b_active);
  // Check bits still pass through so the framing stream stays intact, only unencrypted.
  wire        apply    = in_tail ? t_cipher :
                         ((fmt != `FMT_MULTI) || (sub_pos < `SUB_DATA));
  wire        out_free = !dout_valid || dout_ready;
  wire        step     = busy && ks_valid && (!need || (din_valid && out_free));
  wire        last     = idx == seg_len - 13'd1;

  assign ks_ready  = step;
  assign din_ready = step && need;

  always @(posedge aclk) begin
    if (!aresetn) begin
      dout_valid <= 1'b0;
      dout_bit   <= 1'b0;
    end else begin
      if (step && need) begin
        dout_valid <= 1'b1;
        dout_bit   <= din_bit ^ (apply & ks_bit);
      end else if (dout_ready) begin
        dout_valid <= 1'b0;
      end
    end
  end

  // A write completes only once both address and data are held and no response waits.
  wire wr_go  = aw_hold && w_hold && !s_axi_bvalid;
  wire start  = wr_go && aw_addr == `OFS_START && w_strb[0] && w_data[0] && !busy;
  wire clr_dn = wr_go && aw_addr == `OFS_STATUS && w_strb[0] && w_data[`STATUS_DONE];
  wire set_dn = step && last && seg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      busy    <= 1'b0;
      seg     <= 1'b0;
      done    <= 1'b0;
      idx     <= 13'd0;
      sub_pos <= 7'd0;
    end else begin
      // A pair completing in the same cycle as a clear keeps done set.
      if (set_dn) begin
        done <= 1'b1;
      end else if (clr_dn) begin
        done <= 1'b0;
      end
      if (start) begin
        busy    <= 1'b1;
        seg     <= 1'b0;
        idx     <= 13'd0;
        sub_pos <= 7'd0;
      end else if (step) begin
        // The second segment's last bit ends the pair; the first only flips the segment.
        if (last) begin
          idx     <= 13'd0;
          sub_pos <= 7'd0;
          seg     <= ~seg;
          busy    <= ~seg;
        end else begin
          idx <= idx + 13'd1;
          if (!in_tail) begin
            sub_pos <= (sub_pos == `SUB_LEN - 7'd1) ? 7'd0 : sub_pos + 7'd1;
          end
        end
      end
    end
  end

  // Register map: CTRL holds configuration, slot, B format and tail type; USED holds the
  // B bit count for single-subfield and encoded formats; START launches a pair; STATUS shows
  // busy, current segment and the sticky done flag, which a written one clears.
  // INDEX and SEGLEN are read-only views of the datapath. Other addresses answer SLVERR.
  assign s_axi_awready = !aw_hold;
  assign s_axi_wready  = !w_hold;
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold      <= 1'b0;
      aw_addr      <= 8'h00;
      w_hold       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      ctrl         <= `CTRL_RESET;
      used         <= `USED_RESET;
    end else begin
      if (s_axi_awvalid && !aw_hold) begin
        aw_hold <= 1'b1;
        aw_addr <= word_addr(s_axi_awaddr);
      end
      if (s_axi_wvalid && !w_hold) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        // Settings stay frozen while a pair is in flight.
        if (aw_addr == `OFS_CTRL) begin
          if (!busy && w_strb[0]) begin
            ctrl[7:0] <= w_data[7:0];
          end
          if (!busy && w_strb[1]) begin
            ctrl[15:8] <= w_data[15:8];
          end
        end else if (aw_addr == `OFS_USED) begin
          if (!busy && w_strb[0]) begin
            used[7:0] <= w_data[7:0];
          end
          if (!busy && w_strb[1]) begin
            used[12:8] <= w_data[12:8];
          end
        end else if (aw_addr == `OFS_START || aw_addr == `OFS_STATUS) begin
          s_axi_bresp <= 2'b00;
        end else if (aw_addr == `OFS_INDEX || aw_addr == `OFS_SEGLEN) begin
          s_axi_bresp <= 2'b00;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire [7:0] ra = word_addr(s_axi_araddr);

  // Reads answer one cycle after the address is taken and hold until rready.

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      if (ra == `OFS_CTRL) begin
        s_axi_rdata <= {16'h0000, ctrl};
      end else if (ra == `OFS_USED) begin
        s_axi_rdata <= {19'h0_0000, used};
      end else if (ra == `OFS_START) begin
        s_axi_rdata <= 32'h0000_0000;
      end else if (ra == `OFS_STATUS) begin
        s_axi_rdata <= {29'h0000_0000, done, seg, busy};
      end else if (ra == `OFS_INDEX) begin
        s_axi_rdata <= {19'h0_0000, idx};
      end else if (ra == `OFS_SEGLEN) begin
        s_axi_rdata <= {19'h0_0000, seg_len};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // multilevel_field_encrypt_mapper

`default_nettype wire

// >>> tb/field_mapper_asserts.sv
// Port checker for the field encrypt mapper.
// Assumes it is bound onto the mapper top and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module field_mapper_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ks_valid,
  input wire logic ks_ready,
  input wire logic din_valid,
  input wire logic din_ready,
  input wire logic dout_valid,
  input wire logic dout_bit,
  input wire logic dout_ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  out_hold_a: assert property (dout_valid && !dout_ready |=> dout_valid && $stable(dout_bit))
    else $error("output bit dropped while stalled");
  din_pair_a: assert property (din_ready |-> ks_ready && din_valid)
    else $error("data taken without keystream");
  ks_take_a: assert property (ks_ready |-> ks_valid)
    else $error("keystream taken while not offered");
  out_lat_a: assert property (din_valid && din_ready |=> dout_valid)
    else $error("output bit late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped");
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while data pending");
  cover property (din_valid && din_ready);
  cover property (dout_valid && !dout_ready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (ks_ready && !din_ready);
endmodule // field_mapper_asserts
bind multilevel_field_encrypt_mapper field_mapper_asserts field_mapper_asserts_i (.*);
`default_nettype wire

// >>> tb/ks_source.sv
// Keystream source model: streams pattern bits in index order.
// Assumes restart pulses before each pair; slow thins out valid.
`timescale 1ns/1ns
`default_nettype none
module ks_source (
  input  wire logic        aclk,
  input  wire logic        restart,
  input  wire logic        slow,
  input  wire logic        ks_ready,
  output var  logic        ks_valid,
  output wire logic        ks_bit,
  output var  logic [15:0] count
);
  logic [1:0] ph = 2'd0;
  wire logic  pat = count[0] ^ count[2] ^ count[5];
  // An idle line shows the inverse so that a stale bit cannot pass.
  assign ks_bit = ks_valid ? pat : !pat;
  always @(posedge aclk) begin
    ph <= ph + 2'd1;
    if (restart) count <= 16'h0000;
    else if (ks_valid && ks_ready) count <= count + 16'd1;
    if (restart) ks_valid <= 1'b0;
    else if (!ks_valid || ks_ready) ks_valid <= !slow || ph == 2'd0;
  end
endmodule // ks_source
`default_nettype wire

// >>> tb/test_multilevel_field_encrypt_mapper.sv
// Testbench of the field encrypt mapper: bus tasks, bit streams, expected XOR.
// Assumes the mapper, its register header and the keystream model.
`timescale 1ns/1ns
`default_nettype none
`include "field_mapper_regs.vh"
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin errors++; \
  $display("CHECK FAILED at %0t: got %0h exp %0h", $time, g, x); end end
module test_multilevel_field_encrypt_mapper;
  logic        aclk = 0, aresetn = 0, restart = 1, slow = 0, tc = 0, ex, m;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, din_valid = 1;
  logic        din_bit = 0, dout_ready = 1;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  r, br;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         ks_valid, ks_bit, ks_ready, din_ready, dout_valid, dout_bit;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [15:0]  count;
  int          errors = 0, n_tests = 0, dcnt = 0, tail = 0, len = 1, cyc = 0, k;
  int          per = 1, fm = 0, pos, kidx, p;
  int          cf[9] = '{0, 4, 5, 7, 6, 1, 4, 3, 2}, sl[9] = '{2, 2, 2, 1, 4, 0, 1, 2, 3};
  int          tl[9] = '{40, 80, 120, 40, 40, 40, 80, 40, 40};
  int          ln[9] = '{120, 240, 360, 1960, 2728, 840, 720, 280, 1320};
  int          pr[9] = '{120, 240, 360, 1960, 2728, 840, 180, 90, 1320};
  int          fs[9] = '{0, 0, 0, 0, 0, 2, 3, 1, 1};
  int          us[9] = '{0, 0, 0, 0, 0, 0, 100, 50, 2000};
  bit          q[$];
  multilevel_field_encrypt_mapper multilevel_field_encrypt_mapper_i (.*);
  ks_source ks_source_i (.*);
  always #4 aclk = !aclk;
  function bit kbit(int i);
    return i[0] ^ i[2] ^ i[5];
  endfunction
  task report_and_stop;
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rd(input [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // Expected output is queued when a data bit is taken and compared when it leaves.
  // Data bit n of a pair meets keystream index n mod per in segment n / per.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    dout_ready <= cyc % 7 != 3;
    din_valid <= cyc % 11 != 5;
    if (restart) begin
      dcnt <= 0;
    end else if (din_valid && din_ready) begin
      pos = dcnt % per;
      kidx = dcnt / per * len + pos;
      p = pos - tail;
      m = (pos < tail) ? tc : (fm != 2 || p % 80 < 64);
      q.push_back(din_bit ^ (m & kbit(kidx)));
      dcnt <= dcnt + 1;
      din_bit <= (dcnt + 1) % 5 == 2;
    end
    if (dout_valid && dout_ready) begin
      ex = q.pop_front();
      `CHK(dout_bit, ex)
    end
  end
  initial begin
    #(8 * 100000);
    errors++;
    report_and_stop;
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    restart <= 0;
    rd(`OFS_CTRL);
    `CHK(d[15:0], `CTRL_RESET)
    rd(8'h18);
    `CHK(r, 2'b10)
    wr(8'h18, 0);
    `CHK(br, 2'b10)
    for (int c = 0; c < 9; c++) begin
      tail = tl[c];
      len = ln[c];
      per = pr[c];
      fm = fs[c];
      tc = c % 2 == 0;
      slow <= c % 2;
      restart <= 1;
      wr(`OFS_CTRL, cf[c] | sl[c] << 4 | fm << 8 | tc << 12);
      `CHK(br, 2'b00)
      wr(`OFS_USED, us[c]);
      restart <= 0;
      rd(`OFS_SEGLEN);
      `CHK(d[12:0], len[12:0])
      wr(`OFS_START, 1);
      k = 0;
      do begin
        rd(`OFS_STATUS);
        k++;
      end while (!d[`STATUS_DONE] && k < 9999);
      `CHK(d[2:0], 3'b100)
      `CHK(dcnt, 2 * per)
      `CHK(count, 2 * len)
      rd(`OFS_INDEX);
      `CHK(d[12:0], 13'h0000)
      wr(`OFS_STATUS, 4);
      rd(`OFS_STATUS);
      `CHK(d[`STATUS_DONE], 1'b0)
    end
    repeat (20) @(posedge aclk);
    `CHK(q.size(), 0)
    report_and_stop;
  end
endmodule // test_multilevel_field_encrypt_mapper
`default_nettype wire
